// ### rtl/adp_consts.svh
`ifndef ADP_CONSTS_SVH
`define ADP_CONSTS_SVH

// ************************************************************
// register indices, byte address is four times the index
// ************************************************************
`define ADP_ADDR_PORT_IDX 32'hffff8392
`define ADP_DATA_PORT_IDX 32'hffff83a2

// ************************************************************
// reset values and widths
// ************************************************************
`define ADP_PORT_RST 16'h0000
`define ADP_PORT_W 16
`define ADP_SYNC_RST 16'h0000

// ************************************************************
// axi responses
// ************************************************************
`define ADP_RESP_OKAY 2'h0
`define ADP_RESP_SLVERR 2'h2

`endif

// ### rtl/adp_pkg.sv
package adp_pkg;

  // ************************************************************
  // operating modes as seen on the mode inputs
  // ************************************************************
  typedef enum logic [1:0]
  {
    ADP_MODE_EXP_NOROM0 = 2'h0,
    ADP_MODE_EXP_NOROM1 = 2'h1,
    ADP_MODE_EXP_ROM = 2'h2,
    ADP_MODE_SINGLE = 2'h3
  } adp_mode_e;

  // ************************************************************
  // bus slave states and register select
  // ************************************************************
  typedef enum logic {ADP_WS_IDLE = 1'b0, ADP_WS_RESP = 1'b1} adp_wstate_e;
  typedef enum logic {ADP_RS_IDLE = 1'b0, ADP_RS_DATA = 1'b1} adp_rstate_e;

  typedef enum logic [1:0]
  {
    ADP_SEL_NONE = 2'h0,
    ADP_SEL_ADDR = 2'h1,
    ADP_SEL_DATA = 2'h3
  } adp_sel_e;

  // ************************************************************
  // pin drive bundle and port word
  // ************************************************************
  typedef logic [15:0] adp_word_t;

  typedef struct packed
  {
    logic [15:0] out;
    logic [15:0] oe;
  } adp_pin_s;

endpackage

// ### rtl/adp_sync3.sv
`timescale 1ns/1ps
`include "adp_consts.svh"

module adp_sync3
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // pin side
  input wire logic [15:0] async_in,
  // clock side
  output logic [15:0] sync_out
);

  logic [15:0] s1_q;
  logic [15:0] s2_q;
  logic [15:0] s3_q;
  logic [15:0] out_q;

  // ************************************************************
  // three stages, a bit moves only once stages two and three agree
  // ************************************************************
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s1_q <= `ADP_SYNC_RST;
      s2_q <= `ADP_SYNC_RST;
      s3_q <= `ADP_SYNC_RST;
    end
    else
    begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // per bit: a one-cycle glitch in stage two never reaches the output
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      out_q <= `ADP_SYNC_RST;
    else
      out_q <= (out_q & ~(s2_q ~^ s3_q)) | (s3_q & (s2_q ~^ s3_q));
  end

  assign sync_out = out_q;

endmodule

// ### rtl/adp_top.sv
`timescale 1ns/1ps
`include "adp_consts.svh"

module adp_top
(
  // clock and power-on reset
  input wire logic clk,
  input wire logic rstn,
  // axi4-lite write address
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // mode and pin function control from other units
  input wire logic [1:0] op_mode,
  input wire logic [15:0] address_port_direction,
  input wire logic [15:0] data_port_direction,
  input wire logic [15:0] addr_fn_sel,
  input wire logic [15:0] data_fn_sel,
  // external bus unit
  input wire logic [15:0] bus_addr,
  input wire logic [15:0] bus_data_out,
  input wire logic bus_data_oe,
  output logic [15:0] bus_data_in,
  // address-shared pins
  input wire logic [15:0] addr_pin_in,
  output adp_pkg::adp_pin_s addr_pin_drv,
  // data-shared pins
  input wire logic [15:0] data_pin_in,
  output adp_pkg::adp_pin_s data_pin_drv
);

  localparam logic [31:0] ADDR_IDX = `ADP_ADDR_PORT_IDX;
  localparam logic [31:0] DATA_IDX = `ADP_DATA_PORT_IDX;

  // ************************************************************
  // decode helpers
  // ************************************************************
  // word address only, lanes are chosen by the strobes
  function automatic adp_pkg::adp_sel_e decode(input logic [31:0] a);
    adp_pkg::adp_sel_e s;
    s = adp_pkg::ADP_SEL_NONE;
    if (a[31:2] == ADDR_IDX[29:0])
      s = adp_pkg::ADP_SEL_ADDR;
    else if (a[31:2] == DATA_IDX[29:0])
      s = adp_pkg::ADP_SEL_DATA;
    return s;
  endfunction

  // strobe 1 writes the upper byte, bits 15:8; strobes 3 and 2 are ignored
  function automatic adp_pkg::adp_word_t lane_merge
  (
    input adp_pkg::adp_word_t old_v,
    input logic [15:0] wd,
    input logic [1:0] strb
  );
    adp_pkg::adp_word_t m;
    m = old_v;
    if (strb[1])
      m[15:8] = wd[15:8];
    if (strb[0])
      m[7:0] = wd[7:0];
    return m;
  endfunction

  // ************************************************************
  // state
  // ************************************************************
  adp_pkg::adp_word_t address_port_data_q;
  adp_pkg::adp_word_t data_port_data_low_q;
  adp_pkg::adp_wstate_e ws_q;
  adp_pkg::adp_rstate_e rs_q;
  logic aw_got_q;
  logic w_got_q;
  logic [31:0] awaddr_q;
  logic [15:0] wdata_q;
  logic [1:0] wstrb_q;
  logic [1:0] bresp_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic [15:0] addr_pin_sync;
  logic [15:0] data_pin_sync;
  logic [15:0] addr_view;
  logic [15:0] data_view;
  logic [15:0] addr_fn;
  logic [15:0] data_fn;
  logic [15:0] addr_out_d;
  logic [15:0] addr_oe_d;
  logic [15:0] data_out_d;
  logic [15:0] data_oe_d;
  logic aw_hs;
  logic w_hs;
  logic ar_hs;
  logic wr_commit;
  logic addr_bus_all;
  logic rom_mode;
  adp_pkg::adp_sel_e wsel;
  adp_pkg::adp_sel_e rsel;

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  adp_sync3 u_addr_sync
  (
    .clk(clk),
    .rstn(rstn),
    .async_in(addr_pin_in),
    .sync_out(addr_pin_sync)
  );

  adp_sync3 u_data_sync
  (
    .clk(clk),
    .rstn(rstn),
    .async_in(data_pin_in),
    .sync_out(data_pin_sync)
  );

  // data bus reads from the pins go through the same filter
  assign bus_data_in = data_pin_sync;

  // ************************************************************
  // pin function and read view
  // ************************************************************
  assign addr_bus_all = (op_mode == adp_pkg::ADP_MODE_EXP_NOROM0) ||
                        (op_mode == adp_pkg::ADP_MODE_EXP_NOROM1);
  assign rom_mode = (op_mode == adp_pkg::ADP_MODE_EXP_ROM);

  generate
    for (genvar n = 0; n < `ADP_PORT_W; n++)
    begin : g_bit
      // modes 0/1 force the bus, mode 2 per pin, single-chip never
      assign addr_fn[n] = addr_bus_all |
        (rom_mode & addr_fn_sel[n]);
      assign data_fn[n] = addr_bus_all |
        (rom_mode & data_fn_sel[n]);

      // general function: direction bit gates the stored bit
      assign addr_out_d[n] = addr_fn[n] ? bus_addr[n]
                                        : address_port_data_q[n];
      assign addr_oe_d[n] = addr_fn[n]
                            | address_port_direction[n];
      assign data_out_d[n] = data_fn[n] ? bus_data_out[n]
                                        : data_port_data_low_q[n];
      assign data_oe_d[n] = data_fn[n] ? bus_data_oe
                                       : data_port_direction[n];

      // read path ignores the pin function, only direction counts
      assign addr_view[n] = address_port_direction[n]
                            ? address_port_data_q[n]
                            : addr_pin_sync[n];
      assign data_view[n] = data_port_direction[n]
                            ? data_port_data_low_q[n]
                            : data_pin_sync[n];
    end
  endgenerate

  // registered so the pads never see decode glitches, costs one cycle
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      addr_pin_drv <= '0;
      data_pin_drv <= '0;
    end
    else
    begin
      addr_pin_drv.out <= addr_out_d;
      addr_pin_drv.oe <= addr_oe_d;
      data_pin_drv.out <= data_out_d;
      data_pin_drv.oe <= data_oe_d;
    end
  end

  // ************************************************************
  // write channels
  // ************************************************************
  assign s_axi_awready = (ws_q == adp_pkg::ADP_WS_IDLE) && !aw_got_q;
  assign s_axi_wready = (ws_q == adp_pkg::ADP_WS_IDLE) && !w_got_q;
  assign aw_hs = s_axi_awvalid && s_axi_awready;
  assign w_hs = s_axi_wvalid && s_axi_wready;
  assign wr_commit = (ws_q == adp_pkg::ADP_WS_IDLE) && aw_got_q && w_got_q;
  assign wsel = decode(awaddr_q);

  // address and data may arrive in either order
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      aw_got_q <= 1'b0;
      awaddr_q <= 32'h0000_0000;
    end
    else if (aw_hs)
    begin
      aw_got_q <= 1'b1;
      awaddr_q <= s_axi_awaddr;
    end
    else if (wr_commit)
      aw_got_q <= 1'b0;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      w_got_q <= 1'b0;
      wdata_q <= 16'h0000;
      wstrb_q <= 2'h0;
    end
    else if (w_hs)
    begin
      w_got_q <= 1'b1;
      wdata_q <= s_axi_wdata[15:0];
      wstrb_q <= s_axi_wstrb[1:0];
    end
    else if (wr_commit)
      w_got_q <= 1'b0;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ws_q <= adp_pkg::ADP_WS_IDLE;
      bresp_q <= `ADP_RESP_OKAY;
    end
    else
    begin
      case (ws_q)
        adp_pkg::ADP_WS_IDLE:
        begin
          if (wr_commit)
          begin
            ws_q <= adp_pkg::ADP_WS_RESP;
            bresp_q <= (wsel == adp_pkg::ADP_SEL_NONE) ? `ADP_RESP_SLVERR
                                                       : `ADP_RESP_OKAY;
          end
        end
        adp_pkg::ADP_WS_RESP:
        begin
          if (s_axi_bready)
            ws_q <= adp_pkg::ADP_WS_IDLE;
        end
        default:
          ws_q <= adp_pkg::ADP_WS_IDLE;
      endcase
    end
  end

  assign s_axi_bvalid = (ws_q == adp_pkg::ADP_WS_RESP);
  assign s_axi_bresp = bresp_q;

  // ************************************************************
  // data registers
  // ************************************************************
  // only the power-on reset reaches these; watchdog, standby and
  // sleep have no path here, so contents survive them
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      address_port_data_q <= `ADP_PORT_RST;
    else if (wr_commit && (wsel == adp_pkg::ADP_SEL_ADDR))
      address_port_data_q <= lane_merge(address_port_data_q, wdata_q,
                                        wstrb_q);
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      data_port_data_low_q <= `ADP_PORT_RST;
    else if (wr_commit && (wsel == adp_pkg::ADP_SEL_DATA))
      data_port_data_low_q <= lane_merge(data_port_data_low_q, wdata_q,
                                         wstrb_q);
  end

  // ************************************************************
  // read channels
  // ************************************************************
  assign s_axi_arready = (rs_q == adp_pkg::ADP_RS_IDLE);
  assign ar_hs = s_axi_arvalid && s_axi_arready;
  assign rsel = decode(s_axi_araddr);

  // the pin level is sampled at the address handshake, not later
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rs_q <= adp_pkg::ADP_RS_IDLE;
      rdata_q <= 32'h0000_0000;
      rresp_q <= `ADP_RESP_OKAY;
    end
    else
    begin
      case (rs_q)
        adp_pkg::ADP_RS_IDLE:
        begin
          if (ar_hs)
          begin
            rs_q <= adp_pkg::ADP_RS_DATA;
            case (rsel)
              adp_pkg::ADP_SEL_ADDR:
              begin
                rdata_q <= {16'h0000, addr_view};
                rresp_q <= `ADP_RESP_OKAY;
              end
              adp_pkg::ADP_SEL_DATA:
              begin
                rdata_q <= {16'h0000, data_view};
                rresp_q <= `ADP_RESP_OKAY;
              end
              default:
              begin
                rdata_q <= 32'h0000_0000;
                rresp_q <= `ADP_RESP_SLVERR;
              end
            endcase
          end
        end
        adp_pkg::ADP_RS_DATA:
        begin
          if (s_axi_rready)
            rs_q <= adp_pkg::ADP_RS_IDLE;
        end
        default:
          rs_q <= adp_pkg::ADP_RS_IDLE;
      endcase
    end
  end

  assign s_axi_rvalid = (rs_q == adp_pkg::ADP_RS_DATA);
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

endmodule

// ### tb/adp_top_asserts.sv
`timescale 1ns/1ps
`include "adp_consts.svh"

module adp_top_asserts
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  // mode and function
  input wire logic [1:0] op_mode,
  input wire logic [15:0] address_port_direction,
  input wire logic [15:0] data_port_direction,
  input wire logic [15:0] addr_fn_sel,
  input wire logic [15:0] data_fn_sel,
  input wire logic [15:0] bus_addr,
  input wire logic [15:0] bus_data_out,
  input wire logic bus_data_oe,
  // pins
  input wire adp_pkg::adp_pin_s addr_pin_drv,
  input wire adp_pkg::adp_pin_s data_pin_drv
);
  // ************************************************************
  // bus timing
  // ************************************************************
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence wr_answer;
    !s_axi_awready ##1 s_axi_bvalid;
  endsequence
  a_write_answer: assert property (wr_take |=> wr_answer)
    else $error("write answer missing");
  a_read_answer: assert property
    (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer missing");
  a_resp_holds: assert property
    (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_unmapped_read: assert property
    (s_axi_arvalid && s_axi_arready
      && (s_axi_araddr & 32'hfffffffc) != (`ADP_ADDR_PORT_IDX << 2)
      && (s_axi_araddr & 32'hfffffffc) != (`ADP_DATA_PORT_IDX << 2)
      |=> s_axi_rresp == `ADP_RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  // ************************************************************
  // pin function per mode
  // ************************************************************
  // past of reset guards the first edge, where drives still hold reset
  a_exp_addr: assert property
    ($past(rstn) && $past(op_mode) < 2'h2 |->
      addr_pin_drv.oe == 16'hffff && addr_pin_drv.out == $past(bus_addr))
    else $error("address pins not on bus");
  a_exp_data: assert property
    ($past(rstn) && $past(op_mode) < 2'h2 |->
      data_pin_drv.oe == {16{$past(bus_data_oe)}}
      && data_pin_drv.out == $past(bus_data_out))
    else $error("data pins not on bus");
  a_rom_addr: assert property
    ($past(rstn) && $past(op_mode) == 2'h2 |->
      (addr_pin_drv.oe & $past(addr_fn_sel)) == $past(addr_fn_sel)
      && ((addr_pin_drv.out ^ $past(bus_addr)) & $past(addr_fn_sel))
      == 16'h0)
    else $error("selected address pins wrong");
  a_rom_data: assert property
    ($past(rstn) && $past(op_mode) == 2'h2 |->
      (data_pin_drv.oe & $past(data_fn_sel))
      == ($past(data_fn_sel) & {16{$past(bus_data_oe)}}))
    else $error("selected data pins wrong");
  a_single_oe: assert property
    ($past(rstn) && $past(op_mode) == 2'h3 |->
      addr_pin_drv.oe == $past(address_port_direction)
      && data_pin_drv.oe == $past(data_port_direction))
    else $error("pin enable not direction");
endmodule

// ### tb/adp_pin_model.sv
`timescale 1ns/1ps

module adp_pin_model
(
  // device drive
  input wire adp_pkg::adp_pin_s addr_drv,
  input wire adp_pkg::adp_pin_s data_drv,
  // outside levels
  input wire logic [15:0] addr_ext,
  input wire logic [15:0] data_ext,
  // resolved levels
  output logic [15:0] addr_lvl,
  output logic [15:0] data_lvl
);
  // a driven pin shows the device level, an undriven one the outside level
  assign addr_lvl = (addr_drv.oe & addr_drv.out) |
    (~addr_drv.oe & addr_ext);
  assign data_lvl = (data_drv.oe & data_drv.out) |
    (~data_drv.oe & data_ext);
endmodule

// ### tb/address_data_pin_ports_bench.sv
`timescale 1ns/1ps
`include "adp_consts.svh"

module address_data_pin_ports_bench;
  typedef struct packed
  {
    logic [31:0] a;
    logic [31:0] d;
    logic [3:0] s;
    logic [15:0] e;
  } adp_row_s;
  localparam logic [31:0] ap = `ADP_ADDR_PORT_IDX << 2;
  localparam logic [31:0] dp = `ADP_DATA_PORT_IDX << 2;
  logic clk, rstn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, bus_data_oe;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, op_mode, rr;
  logic [15:0] address_port_direction, data_port_direction, addr_fn_sel;
  logic [15:0] data_fn_sel, bus_addr, bus_data_out, bus_data_in;
  logic [15:0] addr_pin_in, data_pin_in, addr_ext, data_ext;
  adp_pkg::adp_pin_s addr_pin_drv, data_pin_drv;
  logic [15:0] pv;
  int num_errors, checks_done;
  adp_row_s rows [5] = '{'{ap, 32'h0000a5c3, 4'h3, 16'ha5c3},
    '{ap, 32'h00007e00, 4'h2, 16'h7ec3}, '{ap, 32'hffff0011, 4'h1, 16'h7e11},
    '{dp, 32'h12345678, 4'hf, 16'h5678}, '{dp, 32'h00009a00, 4'h2, 16'h9a78}};

  adp_top uut
  (
    .clk(clk), .rstn(rstn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .op_mode(op_mode),
    .address_port_direction(address_port_direction),
    .data_port_direction(data_port_direction),
    .addr_fn_sel(addr_fn_sel), .data_fn_sel(data_fn_sel),
    .bus_addr(bus_addr), .bus_data_out(bus_data_out),
    .bus_data_oe(bus_data_oe), .bus_data_in(bus_data_in),
    .addr_pin_in(addr_pin_in), .addr_pin_drv(addr_pin_drv),
    .data_pin_in(data_pin_in), .data_pin_drv(data_pin_drv)
  );
  adp_pin_model pins (.addr_drv(addr_pin_drv), .data_drv(data_pin_drv),
    .addr_ext(addr_ext), .data_ext(data_ext), .addr_lvl(addr_pin_in),
    .data_lvl(data_pin_in));

  always #12.5 clk = ~clk;

  // ************************************************************
  // helpers
  // ************************************************************
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e)
    begin
      num_errors++;
      $display("CHECK FAILED %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic bound(inout int n);
    n++;
    if (n > 50)
    begin
      num_errors++;
      $display("CHECK FAILED %0t bus wait ran out", $time);
      final_report;
    end
  endtask
  // handshakes are judged before the edge so the release lands after it
  task automatic axw(input logic [31:0] a, input logic [31:0] d,
    input logic [3:0] s, output logic [1:0] r);
    logic aw, w, b;
    int n;
    n = 0;
    b = 1'b0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!b)
    begin
      @(negedge clk);
      aw = s_axi_awvalid && s_axi_awready;
      w = s_axi_wvalid && s_axi_wready;
      b = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge clk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
      if (b) s_axi_bready <= 1'b0;
      bound(n);
    end
  endtask
  task automatic axr(input logic [31:0] a);
    logic ar, v;
    int n;
    n = 0;
    v = 1'b0;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!v)
    begin
      @(negedge clk);
      ar = s_axi_arvalid && s_axi_arready;
      v = s_axi_rvalid;
      rd = s_axi_rdata;
      rr = s_axi_rresp;
      @(posedge clk);
      if (ar) s_axi_arvalid <= 1'b0;
      if (v) s_axi_rready <= 1'b0;
      bound(n);
    end
  endtask

  // ************************************************************
  // sequence
  // ************************************************************
  initial
  begin
    {clk, rstn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, bus_data_oe, s_axi_wstrb} = '0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr, addr_fn_sel} = '0;
    {data_fn_sel, bus_addr, bus_data_out, addr_ext, data_ext} = '0;
    // only the full variant is played, never one without ports
    op_mode = 2'h3;
    address_port_direction = 16'hffff;
    data_port_direction = 16'hffff;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    foreach (rows[i])
    begin
      axw(rows[i].a, rows[i].d, rows[i].s, rr);
      chk(rr, `ADP_RESP_OKAY);
      axr(rows[i].a);
      chk(rd, rows[i].e);
      chk(rr, `ADP_RESP_OKAY);
      @(posedge clk);
      pv = (rows[i].a == ap) ? addr_pin_drv.out : data_pin_drv.out;
      chk(pv, rows[i].e);
    end
    $display("test rows done");
    // inputs read as pin levels, writes stay off the pin
    address_port_direction <= 16'h0;
    data_port_direction <= 16'h0;
    addr_ext <= 16'h3c5a;
    data_ext <= 16'hc3a5;
    axw(ap, 32'h0000ffff, 4'h3, rr);
    repeat (6) @(posedge clk);
    axr(ap);
    chk(rd, 32'h3c5a);
    chk(addr_pin_drv.oe, 16'h0);
    axr(dp);
    chk(rd, 32'hc3a5);
    chk(bus_data_in, 16'hc3a5);
    address_port_direction <= 16'hffff;
    data_port_direction <= 16'hffff;
    axr(ap);
    chk(rd, 32'hffff);
    chk(addr_pin_in, 16'hffff);
    $display("test levels done");
    // shared functions in expanded modes
    op_mode <= 2'h2;
    addr_fn_sel <= 16'hff00;
    data_fn_sel <= 16'h00ff;
    bus_addr <= 16'h1234;
    bus_data_out <= 16'h5a5a;
    bus_data_oe <= 1'b1;
    axw(ap, 32'h00000f0f, 4'h3, rr);
    @(posedge clk);
    chk(addr_pin_drv.out, 16'h120f);
    chk(data_pin_drv.out, 16'h9a5a);
    axr(ap);
    chk(rd, 32'h0f0f);
    op_mode <= 2'h0;
    bus_addr <= 16'hbeef;
    repeat (2) @(posedge clk);
    chk(addr_pin_drv.out, 16'hbeef);
    chk(data_pin_drv.oe, 16'hffff);
    $display("test modes done");
    // unmapped place is refused
    axw(32'h00000010, 32'h0000ffff, 4'hf, rr);
    chk(rr, `ADP_RESP_SLVERR);
    axr(32'h00000010);
    chk(rr, `ADP_RESP_SLVERR);
    chk(rd, 32'h00000000);
    // the refused write must have left the stored word alone
    axr(ap);
    chk(rd, 32'h00000f0f);
    // power-on reset clears both registers
    rstn <= 1'b0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    axr(ap);
    chk(rd, 32'h0);
    axr(dp);
    chk(rd, 32'h0);
    $display("test reset done");
    final_report;
  end
endmodule

bind adp_top adp_top_asserts u_asserts
(
  .clk(clk), .rstn(rstn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .op_mode(op_mode),
  .address_port_direction(address_port_direction),
  .data_port_direction(data_port_direction),
  .addr_fn_sel(addr_fn_sel), .data_fn_sel(data_fn_sel),
  .bus_addr(bus_addr), .bus_data_out(bus_data_out),
  .bus_data_oe(bus_data_oe),
  .addr_pin_drv(addr_pin_drv), .data_pin_drv(data_pin_drv)
);
